// ---- hw/scb_pkg.sv ----
`default_nettype none
package scb_pkg;
    // ==========================================================
    // serial frame layout
    localparam int SCB_FRAME_BITS = 24;
    localparam logic [4:0] SCB_FRAME_LAST = 5'd23;
    localparam logic [4:0] SCB_HDR_BITS = 5'd8;
    localparam int SCB_RW_BIT = 23;
    localparam int SCB_ADDR_MSB = 22;
    localparam int SCB_ADDR_LSB = 16;
    localparam int SCB_DATA_W = 16;

    // ==========================================================
    // register map: address and value after reset per entry
    localparam int SCB_NUM_REGS = 24;
    localparam logic [6:0] SCB_REG_ADDR [SCB_NUM_REGS] = '{
        7'h00, 7'h08, 7'h13, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24,
        7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h2c,
        7'h2d, 7'h2e, 7'h2f, 7'h30, 7'h3b, 7'h3d, 7'h3e, 7'h40};
    localparam logic [15:0] SCB_REG_RST [SCB_NUM_REGS] = '{
        16'h221c, 16'h1084, 16'h0005, 16'h210a, 16'h2a0a, 16'hc3ca,
        16'h0019, 16'h0000, 16'h4000, 16'h0000, 16'h8004, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020,
        16'h00c0, 16'h03fc, 16'h0000, 16'h0000, 16'h0000, 16'h0010};

    // indexes of entries the block's own logic uses
    localparam int SCB_IDX_MAIN = 0;
    localparam int SCB_IDX_AMP_OVR = 1;
    localparam int SCB_IDX_AMP_SET = 2;
    localparam int SCB_IDX_DEN_HI = 11;
    localparam int SCB_IDX_DEN_LO = 12;
    localparam int SCB_IDX_SEED_HI = 13;
    localparam int SCB_IDX_SEED_LO = 14;
    localparam int SCB_IDX_NUM_HI = 15;
    localparam int SCB_IDX_NUM_LO = 16;

    // ==========================================================
    // main control field positions
    localparam int SCB_LOCK_DETECT_ENABLE_BIT = 13;
    localparam int SCB_HI_ADJ_MSB = 8;
    localparam int SCB_HI_ADJ_LSB = 7;
    localparam int SCB_LO_ADJ_MSB = 6;
    localparam int SCB_LO_ADJ_LSB = 5;
    localparam int SCB_AMPLITUDE_CAL_ENABLE_BIT = 4;
    localparam int SCB_FREQUENCY_CAL_ENABLE_BIT = 3;
    localparam int SCB_STAT_SEL_BIT = 2;
    localparam int SCB_SOFT_RST_BIT = 1;
    localparam int SCB_PWR_DN_BIT = 0;

    // amplitude override and setting fields
    localparam int SCB_AMP_OVR_BIT = 13;
    localparam int SCB_AMP_SET_MSB = 11;
    localparam int SCB_AMP_SET_LSB = 3;
endpackage
`default_nettype wire

// ---- hw/scb_sync.sv ----
`default_nettype none
// ==========================================================
// two-flop synchroniser for levels from outside clk_sys
module scb_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // scb_sync
`default_nettype wire

// ---- hw/scb_link.sv ----
`default_nettype none
// ==========================================================
// serial link end: runs on the host's clock, idle outside frames
module scb_link
    import scb_pkg::*;
(
    input wire logic link_clk,
    input wire logic srst,
    input wire logic link_sel_n,
    input wire logic link_data_in,
    input wire logic [15:0] rd_word,
    output logic [23:0] frame_word,
    output logic frame_tgl,
    output logic readback_bit
);
    logic [4:0] bit_cnt_reg;
    logic [22:0] shift_reg;
    wire frame_done = (bit_cnt_reg == SCB_FRAME_LAST);
    wire in_data_phase = (bit_cnt_reg >= SCB_HDR_BITS) && (bit_cnt_reg <= SCB_FRAME_LAST);
    wire [4:0] rb_diff = SCB_FRAME_LAST - bit_cnt_reg;
    wire [3:0] rb_idx = rb_diff[3:0];

    // ==========================================================
    // bit counter and shifter, cleared by the frame's own select
    always_ff @(posedge link_clk or posedge link_sel_n) begin
        if (link_sel_n) begin
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end else begin
            // msb first; bits past the 24th are ignored
            if (bit_cnt_reg < 5'(SCB_FRAME_BITS)) begin
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
            shift_reg <= {shift_reg[21:0], link_data_in};
        end
    end

    // whole frame held stable here, announced by a toggle
    always_ff @(posedge link_clk or posedge srst) begin
        if (srst) begin
            frame_word <= '0;
            frame_tgl <= 1'b0;
        end else if (frame_done) begin
            frame_word <= {shift_reg, link_data_in};
            frame_tgl <= ~frame_tgl;
        end
    end

    // readback shifted out on falling edges during the data phase
    always_ff @(negedge link_clk or posedge link_sel_n) begin
        if (link_sel_n) begin
            readback_bit <= 1'b0;
        end else if (in_data_phase) begin
            readback_bit <= rd_word[rb_idx];
        end else begin
            readback_bit <= 1'b0;
        end
    end

    chk_frame_length:
    assert property (@(posedge link_clk) disable iff (srst)
        $changed(frame_tgl) |-> $past(bit_cnt_reg) == SCB_FRAME_LAST)
    else $error("frame taken at wrong bit count");
endmodule // scb_link
`default_nettype wire

// ---- hw/scb_bank.sv ----
`default_nettype none
module scb_bank
    import scb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic link_data_in,
    input wire logic lock_raw,
    output logic status_output_pin,
    output logic lock_detect_enable,
    output logic [1:0] freq_cal_high_rate_adjust,
    output logic [1:0] freq_cal_low_rate_adjust,
    output logic amplitude_cal_auto,
    output logic amplitude_override,
    output logic [8:0] amplitude_setting,
    output logic frequency_cal_enable,
    output logic frequency_cal_start,
    output logic device_reset,
    output logic power_down,
    output logic [31:0] fraction_numerator,
    output logic [31:0] fraction_denominator,
    output logic [31:0] modulator_seed
);
    // ==========================================================
    // declarations
    logic [15:0] regs [SCB_NUM_REGS];
    logic [15:0] rd_word_reg;
    logic tgl_seen_reg;
    logic locked_ind_reg;
    logic acal_auto_reg;
    logic fcal_start_reg;
    logic dev_rst_reg;
    logic [23:0] frame_word;
    logic frame_tgl;
    logic readback_bit;
    logic tgl_sync;
    logic lock_sync;
    logic [SCB_NUM_REGS-1:0] hit;
    logic [15:0] rd_acc [SCB_NUM_REGS+1];

    // ==========================================================
    // link end and crossings
    scb_link u_link (
        .link_clk(link_clk),
        .srst(srst),
        .link_sel_n(link_sel_n),
        .link_data_in(link_data_in),
        .rd_word(rd_word_reg),
        .frame_word(frame_word),
        .frame_tgl(frame_tgl),
        .readback_bit(readback_bit)
    );

    // toggle and lock level both pass two flops
    scb_sync #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in({frame_tgl, lock_raw}),
        .sync_out({tgl_sync, lock_sync})
    );

    // ==========================================================
    // frame decode; the word has been stable for two cycles already
    wire frame_pulse = (tgl_sync != tgl_seen_reg);
    wire frame_rd = frame_word[SCB_RW_BIT];
    wire [6:0] frame_addr = frame_word[SCB_ADDR_MSB:SCB_ADDR_LSB];
    wire [15:0] wdata = frame_word[SCB_DATA_W-1:0];
    wire wr_en = frame_pulse && !frame_rd;
    wire rd_en = frame_pulse && frame_rd;
    wire wr_main = wr_en && hit[SCB_IDX_MAIN];
    // reset bit wins over every other field in the same write
    wire soft_rst = wr_main && wdata[SCB_SOFT_RST_BIT];
    wire fcal_req = wr_main && wdata[SCB_FREQUENCY_CAL_ENABLE_BIT] && !soft_rst;
    wire [15:0] main_ctrl = regs[SCB_IDX_MAIN];
    wire amp_ovr_bit = regs[SCB_IDX_AMP_OVR][SCB_AMP_OVR_BIT];

    // ==========================================================
    // register storage, one entry per generate step
    for (genvar i = 0; i < SCB_NUM_REGS; i++) begin : g_reg
        assign hit[i] = (frame_addr == SCB_REG_ADDR[i]);
        assign rd_acc[i+1] = rd_acc[i] | (hit[i] ? regs[i] : 16'h0000);

        // the reset bit never stores: defaults reload, so it reads 0
        always_ff @(posedge clk_sys) begin
            if (srst || soft_rst) begin
                regs[i] <= SCB_REG_RST[i];
            end else if (wr_en && hit[i]) begin
                regs[i] <= wdata;
            end
        end
    end
    assign rd_acc[0] = 16'h0000;

    // ==========================================================
    // toggle tracking and readback word; unmapped addresses read 0
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tgl_seen_reg <= 1'b0;
            rd_word_reg <= 16'h0000;
        end else begin
            tgl_seen_reg <= tgl_sync;
            if (rd_en) begin
                rd_word_reg <= rd_acc[SCB_NUM_REGS];
            end
        end
    end

    // ==========================================================
    // derived controls and one-cycle events
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            locked_ind_reg <= 1'b0;
            acal_auto_reg <= 1'b0;
            fcal_start_reg <= 1'b0;
            dev_rst_reg <= 1'b0;
        end else begin
            // lock shows only while detection is enabled
            locked_ind_reg <= main_ctrl[SCB_LOCK_DETECT_ENABLE_BIT] && lock_sync;
            // override bypasses automatic amplitude; off when powered down
            acal_auto_reg <= main_ctrl[SCB_AMPLITUDE_CAL_ENABLE_BIT] && !amp_ovr_bit
                && !main_ctrl[SCB_PWR_DN_BIT];
            fcal_start_reg <= fcal_req;
            dev_rst_reg <= soft_rst;
        end
    end

    // ==========================================================
    // outputs; all come from register bits or flops above
    assign lock_detect_enable = main_ctrl[SCB_LOCK_DETECT_ENABLE_BIT];
    assign freq_cal_high_rate_adjust = main_ctrl[SCB_HI_ADJ_MSB:SCB_HI_ADJ_LSB];
    assign freq_cal_low_rate_adjust = main_ctrl[SCB_LO_ADJ_MSB:SCB_LO_ADJ_LSB];
    assign frequency_cal_enable = main_ctrl[SCB_FREQUENCY_CAL_ENABLE_BIT];
    assign power_down = main_ctrl[SCB_PWR_DN_BIT];
    assign amplitude_override = amp_ovr_bit;
    assign amplitude_setting = regs[SCB_IDX_AMP_SET][SCB_AMP_SET_MSB:SCB_AMP_SET_LSB];
    assign amplitude_cal_auto = acal_auto_reg;
    assign frequency_cal_start = fcal_start_reg;
    assign device_reset = dev_rst_reg;
    // upper halves sit at the lower address
    assign fraction_numerator = {regs[SCB_IDX_NUM_HI], regs[SCB_IDX_NUM_LO]};
    assign fraction_denominator = {regs[SCB_IDX_DEN_HI], regs[SCB_IDX_DEN_LO]};
    assign modulator_seed = {regs[SCB_IDX_SEED_HI], regs[SCB_IDX_SEED_LO]};
    // readback toggles at link rate, too fast to retime into clk_sys
    assign status_output_pin = main_ctrl[SCB_STAT_SEL_BIT] ? locked_ind_reg
        : readback_bit;

    // ==========================================================
    // checks
    chk_ld_after_reset:
    assert property (@(posedge clk_sys) $past(srst) && !srst |-> lock_detect_enable)
    else $error("lock detect not enabled after reset");

    chk_hi_adj_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(freq_cal_high_rate_adjust) |-> $past(wr_main))
    else $error("high rate adjust changed without a write");

    chk_lo_adj_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(freq_cal_low_rate_adjust) |-> $past(wr_main))
    else $error("low rate adjust changed without a write");

    chk_amp_auto_on:
    assert property (@(posedge clk_sys) disable iff (srst)
        (main_ctrl[SCB_AMPLITUDE_CAL_ENABLE_BIT] && !amp_ovr_bit && !power_down)[*2]
        |-> amplitude_cal_auto)
    else $error("automatic amplitude not active");

    chk_fcal_pulse:
    assert property (@(posedge clk_sys) disable iff (srst)
        fcal_req |=> frequency_cal_start && frequency_cal_enable ##1 !frequency_cal_start)
    else $error("calibration start not a single pulse");

    chk_status_lock:
    assert property (@(posedge clk_sys) disable iff (srst)
        (main_ctrl[SCB_STAT_SEL_BIT] && lock_detect_enable && lock_sync)[*2]
        |-> status_output_pin)
    else $error("status pin not showing lock");

    chk_soft_reset:
    assert property (@(posedge clk_sys) disable iff (srst)
        soft_rst |=> device_reset && !main_ctrl[SCB_SOFT_RST_BIT]
        && main_ctrl == SCB_REG_RST[SCB_IDX_MAIN] ##1 !device_reset)
    else $error("soft reset did not reload defaults");

    chk_power_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(power_down) |-> $past(wr_main))
    else $error("power down changed without a write");

    chk_amp_override:
    assert property (@(posedge clk_sys) disable iff (srst)
        amp_ovr_bit |=> !amplitude_cal_auto)
    else $error("automatic amplitude active under override");

    // ==========================================================
    // checks on what may move a control, and on pulse shapes
    chk_ld_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(lock_detect_enable) |-> $past(wr_main))
    else $error("lock detect enable changed without a write");

    // with detection off the pin must not claim lock
    chk_ld_gates_status:
    assert property (@(posedge clk_sys) disable iff (srst)
        (main_ctrl[SCB_STAT_SEL_BIT] && !lock_detect_enable)[*2]
        |-> !status_output_pin)
    else $error("status pin shows lock with detection off");

    chk_amp_auto_off:
    assert property (@(posedge clk_sys) disable iff (srst)
        !main_ctrl[SCB_AMPLITUDE_CAL_ENABLE_BIT] |=> !amplitude_cal_auto)
    else $error("automatic amplitude active while disabled");

    chk_fcal_cause:
    assert property (@(posedge clk_sys) disable iff (srst)
        frequency_cal_start |-> $past(fcal_req))
    else $error("calibration start without a write");

    chk_frequency_cal_enable_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(frequency_cal_enable) |-> $past(wr_main))
    else $error("calibration enable changed without a write");

    // outside a frame the readback flop idles low
    chk_readback_idle:
    assert property (@(posedge clk_sys) disable iff (srst)
        !main_ctrl[SCB_STAT_SEL_BIT] && link_sel_n |-> !status_output_pin)
    else $error("status pin busy outside a frame");

    // the reset write must not also start a calibration
    chk_reset_no_cal:
    assert property (@(posedge clk_sys) disable iff (srst)
        soft_rst |=> !frequency_cal_start)
    else $error("calibration started by a reset write");

    chk_reset_cause:
    assert property (@(posedge clk_sys) disable iff (srst)
        device_reset |-> $past(soft_rst))
    else $error("device reset without a reset write");

    chk_pd_auto_off:
    assert property (@(posedge clk_sys) disable iff (srst)
        power_down |=> !amplitude_cal_auto)
    else $error("automatic amplitude active while powered down");

    // override and setting are plain registers
    chk_ovr_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(amplitude_override) |-> $past(wr_en))
    else $error("override changed without a write");

    chk_amp_set_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(amplitude_setting) |-> $past(wr_en))
    else $error("amplitude setting changed without a write");

    // toggle edge must be taken once, or a write would land twice
    chk_frame_pulse_once:
    assert property (@(posedge clk_sys) disable iff (srst)
        frame_pulse |=> !frame_pulse)
    else $error("frame announced twice");

    chk_read_no_change:
    assert property (@(posedge clk_sys) disable iff (srst)
        rd_en |=> $stable(main_ctrl) && $stable(fraction_numerator)
        && $stable(modulator_seed))
    else $error("read frame changed a register");

    // wide values may move only after a write frame, including a reset write to the main control
    chk_num_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(fraction_numerator) |-> $past(wr_en))
    else $error("numerator changed without a write");

    chk_den_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(fraction_denominator) |-> $past(wr_en))
    else $error("denominator changed without a write");

    chk_seed_write:
    assert property (@(posedge clk_sys) disable iff (srst)
        $changed(modulator_seed) |-> $past(wr_en))
    else $error("modulator seed changed without a write");
endmodule // scb_bank
`default_nettype wire

// ---- tb/scb_host.sv ----
`default_nettype none
// ==========================================================
// host end of the serial link: clock runs only inside frames
module scb_host (
    output logic link_clk,
    output logic link_sel_n,
    output logic link_data_in,
    input wire logic status_output_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        link_clk = 1'b0;
        link_sel_n = 1'b1;
        link_data_in = 1'b1;
    end

    // one frame msb first, readback taken at rising edges 9 to 24
    task automatic frame(input logic [23:0] w, output logic [15:0] rd);
        rd = 16'h0000;
        #7 link_sel_n = 1'b0;
        for (int i = 0; i < 24; i++) begin
            link_data_in = w[23-i];
            #15;
            if (i >= 8) rd = {rd[14:0], status_output_pin};
            link_clk = 1'b1;
            #15 link_clk = 1'b0;
        end
        #15 link_sel_n = 1'b1;
        // released line shows the inverse so a stale bit is never read
        link_data_in = ~link_data_in;
        // covers the crossing plus the minimum spacing of frames
        #500;
    endtask

    // frame broken off after 16 bits: must leave every register alone
    task automatic cut_frame(input logic [23:0] w);
        #7 link_sel_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            link_data_in = w[23-i];
            #15 link_clk = 1'b1;
            #15 link_clk = 1'b0;
        end
        #15 link_sel_n = 1'b1;
        link_data_in = ~link_data_in;
        #500;
    endtask
endmodule // scb_host
`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import scb_pkg::*;

    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic lock_raw = 1'b0;
    logic link_clk, link_sel_n, link_data_in, status_output_pin;
    logic lock_detect_enable, amplitude_cal_auto, amplitude_override;
    logic frequency_cal_enable, frequency_cal_start, device_reset, power_down;
    logic [1:0] freq_cal_high_rate_adjust, freq_cal_low_rate_adjust;
    logic [8:0] amplitude_setting;
    logic [31:0] fraction_numerator, fraction_denominator, modulator_seed;
    logic [15:0] rd;
    int n_fail = 0;
    int checks = 0;
    int n_fcal = 0;
    int n_rst = 0;

    scb_bank u_scb_bank (
        .clk_sys, .srst, .link_clk, .link_sel_n, .link_data_in, .lock_raw,
        .status_output_pin, .lock_detect_enable, .freq_cal_high_rate_adjust,
        .freq_cal_low_rate_adjust, .amplitude_cal_auto, .amplitude_override,
        .amplitude_setting, .frequency_cal_enable, .frequency_cal_start,
        .device_reset, .power_down, .fraction_numerator, .fraction_denominator,
        .modulator_seed
    );

    scb_host u_scb_host (.link_clk, .link_sel_n, .link_data_in, .status_output_pin);

    always #25 clk_sys = ~clk_sys;

    // pulse counters, so a doubled or missing pulse shows up
    always @(posedge clk_sys) begin
        if (frequency_cal_start === 1'b1) n_fcal <= n_fcal + 1;
        if (device_reset === 1'b1) n_rst <= n_rst + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] r;
        u_scb_host.frame({1'b0, a, d}, r);
    endtask

    // readback is pipelined: the second frame carries the data
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] r;
        u_scb_host.frame({1'b1, a, 16'h0000}, r);
        u_scb_host.frame({1'b1, a, 16'h0000}, r);
        chk(r, exp);
    endtask

    task automatic results;
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog: about 54 frames of 1.24 us each, with ample margin
    initial begin
        #400us;
        n_fail++;
        results();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(lock_detect_enable, 1'b1);
        chk(freq_cal_high_rate_adjust, 2'h0);
        chk(freq_cal_low_rate_adjust, 2'h0);
        chk(amplitude_cal_auto, 1'b1);
        chk(frequency_cal_enable, 1'b1);
        chk(power_down, 1'b0);
        chk(status_output_pin, 1'b0);
        lock_raw <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(status_output_pin, 1'b1);
        wr(7'h00, 16'h021c);
        chk(lock_detect_enable, 1'b0);
        chk(status_output_pin, 1'b0);
        chk(n_fcal, 1);
        wr(7'h00, 16'h221c);
        chk(n_fcal, 2);
        // readback on the pin and calibration off: idle pin, no pulse
        wr(7'h00, 16'h2210);
        chk(n_fcal, 2);
        chk(frequency_cal_enable, 1'b0);
        chk(status_output_pin, 1'b0);
        // whole map read back, each frame returns the previous address
        for (int i = 0; i <= SCB_NUM_REGS; i++) begin
            u_scb_host.frame({1'b1, SCB_REG_ADDR[i % SCB_NUM_REGS], 16'h0000}, rd);
            if (i > 0) chk(rd, (i == 1) ? 16'h2210 : SCB_REG_RST[i-1]);
        end
        wr(7'h01, 16'hbeef);
        rd_chk(7'h01, 16'h0000);
        // every adjust code on both fields
        for (int v = 0; v < 4; v++) begin
            wr(7'h00, 16'h2210 | 16'(v << 7) | 16'((3 - v) << 5));
            chk(freq_cal_high_rate_adjust, v);
            chk(freq_cal_low_rate_adjust, 3 - v);
        end
        rd_chk(7'h00, 16'h2390);
        // wide values change per half, upper half at lower address
        wr(7'h28, 16'h9abc);
        chk(fraction_denominator, 32'h9abc0000);
        wr(7'h29, 16'hdef0);
        chk(fraction_denominator, 32'h9abcdef0);
        wr(7'h2c, 16'h1234);
        wr(7'h2d, 16'h5678);
        chk(fraction_numerator, 32'h12345678);
        wr(7'h2a, 16'h0f1e);
        wr(7'h2b, 16'h2d3c);
        chk(modulator_seed, 32'h0f1e2d3c);
        rd_chk(7'h2c, 16'h1234);
        // a frame cut short leaves the register untouched
        u_scb_host.cut_frame({1'b0, 7'h2c, 16'hffff});
        chk(fraction_numerator, 32'h12345678);
        // manual amplitude: override first, then the setting
        wr(7'h08, 16'h3084);
        wr(7'h13, 16'h0965);
        chk(amplitude_override, 1'b1);
        chk(amplitude_setting, 9'h12c);
        chk(amplitude_cal_auto, 1'b0);
        wr(7'h08, 16'h1084);
        chk(amplitude_cal_auto, 1'b1);
        wr(7'h00, 16'h2200);
        chk(amplitude_cal_auto, 1'b0);
        wr(7'h00, 16'h2211);
        chk(power_down, 1'b1);
        chk(amplitude_cal_auto, 1'b0);
        // reset bit with calibration bit set: reset wins, no cal pulse
        wr(7'h00, 16'h221b);
        chk(n_rst, 1);
        chk(n_fcal, 2);
        chk(power_down, 1'b0);
        chk(fraction_numerator, 32'h0);
        chk(lock_detect_enable, 1'b1);
        chk(status_output_pin, 1'b1);
        // reset in mid-run: defaults back and the link still takes frames
        wr(7'h28, 16'h5555);
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(fraction_denominator, 32'h0);
        chk(amplitude_cal_auto, 1'b1);
        chk(lock_detect_enable, 1'b1);
        wr(7'h2d, 16'h00a5);
        chk(fraction_numerator, 32'h000000a5);
        chk(n_fcal, 2);
        chk(n_rst, 1);
        results();
    end
endmodule // testbench
`default_nettype wire
